// *** roi_window_select_black_level_tb.sv ***
`timescale 1ns/100ps
`include "rwb_regs.svh"

module roi_window_select_black_level_tb;
	import rwb_pkg::*;

	logic            clock;
	logic            rst;
	rwb_reg_req_type reg_in;
	logic [15:0]     reg_read_data;
	logic            gate;
	logic [9:0]      target;
	logic            frame_start;
	logic            frame_end;
	logic            row_start;
	logic [9:0]      dark_sample;
	logic            pixel_valid;
	logic [9:0]      pixel_data;
	logic            pixel_ready;
	rwb_pixel_type   pix_out;
	logic [15:0]     window_active_mask;
	logic            window_switch;
	int              err_total;
	int              compares;
	logic [31:0]     lf;
	logic [11:0]     exp_q[$];
	logic [11:0]     e;
	logic            auto_on;
	logic            sgn;
	logic [8:0]      off;
	logic [15:0]     g0;
	logic [12:0]     lvl[16];

	rwb_readout dut
	(
		.clock                (clock),
		.rst                  (rst),
		.reg_in               (reg_in),
		.reg_read_data        (reg_read_data),
		.dark_row_update_gate (gate),
		.black_level_target   (target),
		.frame_start          (frame_start),
		.frame_end            (frame_end),
		.row_start            (row_start),
		.dark_sample          (dark_sample),
		.pixel_valid          (pixel_valid),
		.pixel_data           (pixel_data),
		.pixel_ready          (pixel_ready),
		.pix_out              (pix_out),
		.window_active_mask   (window_active_mask),
		.window_switch        (window_switch)
	);

	function automatic logic [31:0] step(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	function automatic logic [9:0] img(logic [9:0] p, logic [3:0] c);
		logic [11:0] s;
		if (auto_on)
			s = ({2'h0, p} + {2'h0, target} < {2'h0, lvl[c][12:3]})
				? 12'h000
				: {2'h0, p} + {2'h0, target} - {2'h0, lvl[c][12:3]};
		else if (sgn)
			s = (p < {1'h0, off}) ? 12'h000 : {2'h0, p} - {3'h0, off};
		else
			s = {2'h0, p} + {3'h0, off};
		return (s > 12'h3ff) ? 10'h3ff : s[9:0];
	endfunction

	task chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_total++;
			$display("FAIL %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task wr(input logic [8:0] a, input logic [15:0] d);
		reg_in = '{1'b1, a, d};
		@(negedge clock);
		reg_in.write = 1'b0;
		@(negedge clock);
	endtask

	task rd(input logic [8:0] a, input logic [15:0] exp);
		reg_in = '{1'b0, a, 16'h0000};
		repeat (2) @(negedge clock);
		chk(reg_read_data, exp);
	endtask

	task frame(input int rows, input int blanks, input logic sw,
		input logic [15:0] mask, input int npix);
		int          i;
		logic [9:0]  p;
		logic signed [13:0] df;
		dark_sample = lf[9:0];
		frame_start = 1'b1;
		for (i = 0; i < rows * 2592; i++)
		begin
			exp_q.push_back({1'b1, i < blanks * 2592,
				(i < blanks * 2592) ? 10'h000 : dark_sample});
			// Column levels follow every unblanked dark sample
			if (i >= blanks * 2592)
			begin
				df = $signed({1'b0, dark_sample, 3'h0})
					- $signed({1'b0, lvl[i % 16]});
				lvl[i % 16] = lvl[i % 16] + 13'(df >>> 3);
			end
		end
		@(negedge clock);
		frame_start = 1'b0;
		chk({15'h0, window_switch}, {15'h0, sw});
		chk(window_active_mask, mask);
		@(negedge clock);
		chk({14'h0, window_switch, pixel_ready}, 16'h0000);
		i = 0;
		while (pixel_ready !== 1'b1 && i < 700000)
		begin
			@(negedge clock);
			i++;
		end
		row_start = 1'b1;
		for (i = 0; i < npix; i++)
		begin
			lf = step(lf);
			p = (i == 0) ? 10'h000 : (i == 1) ? 10'h3ff : lf[9:0];
			pixel_valid = 1'b1;
			pixel_data = p;
			exp_q.push_back({2'b00, img(p, i[3:0])});
			@(negedge clock);
			row_start = 1'b0;
		end
		pixel_valid = 1'b0;
		frame_end = 1'b1;
		@(negedge clock);
		frame_end = 1'b0;
		@(negedge clock);
		chk({15'h0, pixel_ready}, 16'h0000);
	endtask

	task stop_test;
		if (err_total == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	always @(negedge clock)
	begin
		if (!rst && pix_out.valid === 1'b1)
		begin
			compares++;
			if (exp_q.size() == 0)
			begin
				err_total++;
				$display("FAIL %0t: unexpected output sample", $time);
			end
			else
			begin
				e = exp_q.pop_front();
				if ({pix_out.dark, pix_out.blank, pix_out.data} !== e)
				begin
					err_total++;
					$display("FAIL %0t: sample %h expected %h", $time,
						{pix_out.dark, pix_out.blank, pix_out.data}, e);
				end
			end
		end
	end

	initial
	begin
		#(25 * 100000);
		err_total++;
		stop_test;
	end

	initial
	begin
		err_total = 0;
		compares = 0;
		lf = 32'h7c4c;
		foreach (lvl[k])
			lvl[k] = 13'h0;
		rst = 1'b1;
		reg_in = '0;
		gate = 1'b1;
		frame_start = 1'b0;
		frame_end = 1'b0;
		row_start = 1'b0;
		dark_sample = 10'h000;
		pixel_valid = 1'b0;
		pixel_data = 10'h000;
		target = 10'h2f0;
		repeat (20) @(negedge clock);
		rst = 1'b0;
		rd(`RWB_CAL_CONTROL_OFFSET, 16'h0001);
		rd(`RWB_WINDOW_ACT_OFFSET, 16'h0001);
		rd(`RWB_DARK_ROW_CFG_OFFSET, 16'h0001);
		rd(9'h0c4, 16'h0000);
		lf = step(lf);
		g0 = lf[15:0];
		wr(`RWB_GEOMETRY_BASE, g0);
		wr(`RWB_GEOMETRY_LAST, ~g0);
		wr(`RWB_WINDOW_ACT_OFFSET, 16'h0003);
		rd(`RWB_GEOMETRY_BASE, g0);
		rd(`RWB_GEOMETRY_LAST, ~g0);
		rd(`RWB_WINDOW_ACT_OFFSET, 16'h0003);
		// Auto mode with stray sign and offset set
		auto_on = 1'b1;
		wr(`RWB_CAL_CONTROL_OFFSET, 16'h0479);
		frame(1, 0, 1'b1, 16'h0003, 6);
		// Manual subtract, two rows with one blanked
		auto_on = 1'b0;
		sgn = 1'b1;
		off = 9'h155;
		wr(`RWB_CAL_CONTROL_OFFSET, {5'h0, sgn, off, 1'b0});
		wr(`RWB_DARK_ROW_CFG_OFFSET, 16'h0102);
		lf = step(lf);
		frame(2, 1, 1'b0, 16'h0003, 6);
		// Manual add; closed gate must keep two rows, one blanked
		sgn = 1'b0;
		off = 9'h1f3;
		wr(`RWB_CAL_CONTROL_OFFSET, {5'h0, sgn, off, 1'b0});
		gate = 1'b0;
		wr(`RWB_DARK_ROW_CFG_OFFSET, 16'h0003);
		wr(`RWB_WINDOW_ACT_OFFSET, 16'h8000);
		lf = step(lf);
		frame(2, 1, 1'b1, 16'h8000, 6);
		gate = 1'b1;
		lf = step(lf);
		frame(3, 0, 1'b0, 16'h8000, 3);
		repeat (4) @(negedge clock);
		chk(16'(exp_q.size()), 16'h0000);
		stop_test;
	end
endmodule

// *** rwb_pkg.sv ***
package rwb_pkg;

	typedef enum logic [1:0]
	{
		RWB_IDLE  = 2'h0,
		RWB_DARK  = 2'h1,
		RWB_IMAGE = 2'h3
	} rwb_state_type;

	typedef struct packed
	{
		logic       write;
		logic [8:0] address;
		logic [15:0] data;
	} rwb_reg_req_type;

	typedef struct packed
	{
		logic       valid;
		logic       dark;
		logic       blank;
		logic [9:0] data;
	} rwb_pixel_type;

endpackage

// *** rwb_readout.sv ***
`timescale 1ns/100ps
`include "rwb_regs.svh"

module rwb_readout
#(
	parameter int KERNELS = `RWB_KERNELS,
	parameter int COLUMNS = `RWB_COLUMNS
)
(
	input  wire logic                     clock,
	input  wire logic                     rst,
	input  wire rwb_pkg::rwb_reg_req_type reg_in,
	output logic [15:0]                   reg_read_data,
	input  wire logic                     dark_row_update_gate,
	input  wire logic [9:0]               black_level_target,
	input  wire logic                     frame_start,
	input  wire logic                     frame_end,
	input  wire logic                     row_start,
	input  wire logic [9:0]               dark_sample,
	input  wire logic                     pixel_valid,
	input  wire logic [9:0]               pixel_data,
	output logic                          pixel_ready,
	output rwb_pkg::rwb_pixel_type        pix_out,
	output logic [15:0]                   window_active_mask,
	output logic                          window_switch
);
	import rwb_pkg::*;

	if (COLUMNS != 16 || KERNELS < 1 || KERNELS > 255)
	begin : bad_geometry
		$error("COLUMNS must be 16 and KERNELS 1 to 255");
	end

	typedef struct packed
	{
		rwb_state_type       state;
		logic [15:0]         cal_ctrl;
		logic [15:0]         win_act;
		logic [15:0]         dark_cfg;
		logic [47:0][15:0]   geometry;
		logic [15:0]         active_mask;
		logic                switch_pulse;
		logic [7:0]          dark_rows;
		logic [4:0]          blank_rows;
		logic [7:0]          row;
		logic [7:0]          kernel;
		logic [3:0]          column;
		logic [15:0][12:0]   level;
		rwb_pixel_type       out;
		logic [15:0]         read_data;
	} rwb_core_type;

	rwb_core_type s;
	rwb_core_type next_s;

	logic               auto_mode;
	logic [8:0]         manual_offset;
	logic               blanked_row;
	logic               last_dark;
	logic [3:0]         image_col;

	assign auto_mode = s.cal_ctrl[`RWB_AUTO_ENABLE_BIT];
	assign manual_offset =
		s.cal_ctrl[`RWB_MANUAL_OFFSET_MSB:`RWB_MANUAL_OFFSET_LSB];
	assign blanked_row = s.row < {3'h0, s.blank_rows};
	assign last_dark = s.column == 4'hf
		&& s.kernel == 8'(KERNELS - 1)
		&& s.row == s.dark_rows - 8'h01;
	// A pixel that arrives with row_start belongs to column zero
	assign image_col = row_start ? 4'h0 : s.column;

	always_comb
	begin
		logic signed [13:0] diff;
		logic [13:0]        stepped;
		logic signed [12:0] sum;
		logic [5:0]         gidx;
		next_s = s;
		diff = 14'sh0;
		stepped = 14'h0;
		sum = 13'sh0;
		gidx = 6'(reg_in.address - `RWB_GEOMETRY_BASE);
		next_s.switch_pulse = 1'b0;
		next_s.out.valid = 1'b0;

		// Geometry of any window, active or not, takes writes at once
		if (reg_in.write)
		begin
			unique case (reg_in.address)
				`RWB_CAL_CONTROL_OFFSET:  next_s.cal_ctrl = reg_in.data;
				`RWB_WINDOW_ACT_OFFSET:   next_s.win_act = reg_in.data;
				`RWB_DARK_ROW_CFG_OFFSET: next_s.dark_cfg = reg_in.data;
				default:
				begin
					if (reg_in.address >= `RWB_GEOMETRY_BASE
						&& reg_in.address <= `RWB_GEOMETRY_LAST)
					begin
						next_s.geometry[gidx] = reg_in.data;
					end
				end
			endcase
		end

		unique case (reg_in.address)
			`RWB_CAL_CONTROL_OFFSET:  next_s.read_data = s.cal_ctrl;
			`RWB_WINDOW_ACT_OFFSET:   next_s.read_data = s.win_act;
			`RWB_DARK_ROW_CFG_OFFSET: next_s.read_data = s.dark_cfg;
			default:
			begin
				if (reg_in.address >= `RWB_GEOMETRY_BASE
					&& reg_in.address <= `RWB_GEOMETRY_LAST)
				begin
					next_s.read_data = s.geometry[gidx];
				end
				else
				begin
					next_s.read_data = 16'h0;
				end
			end
		endcase

		unique case (s.state)
			RWB_IDLE:
			begin
			end
			RWB_DARK:
			begin
				// Dark samples go out raw; blanked rows read zero
				next_s.out.valid = 1'b1;
				next_s.out.dark = 1'b1;
				next_s.out.blank = blanked_row;
				next_s.out.data = blanked_row ? 10'h0 : dark_sample;
				if (!blanked_row)
				begin
					// Per-column low-pass level, three fraction bits
					diff = $signed({1'b0, dark_sample, 3'h0})
						- $signed({1'b0, s.level[s.column]});
					stepped = {1'b0, s.level[s.column]}
						+ 14'(diff >>> 3);
					next_s.level[s.column] = stepped[12:0];
				end
				next_s.column = s.column + 4'h1;
				if (s.column == 4'hf)
				begin
					next_s.kernel = s.kernel + 8'h01;
					if (s.kernel == 8'(KERNELS - 1))
					begin
						next_s.kernel = 8'h0;
						next_s.row = s.row + 8'h01;
					end
				end
				if (last_dark)
				begin
					next_s.state = RWB_IMAGE;
					next_s.column = 4'h0;
				end
			end
			RWB_IMAGE:
			begin
				if (row_start)
				begin
					next_s.column = 4'h0;
				end
				if (pixel_valid)
				begin
					if (auto_mode)
					begin
						// Sign bit plays no part here
						sum = 13'(pixel_data) + 13'(black_level_target)
							- 13'(s.level[image_col][12:3]);
					end
					else if (s.cal_ctrl[`RWB_OFFSET_SIGN_BIT])
					begin
						sum = 13'(pixel_data) - 13'(manual_offset);
					end
					else
					begin
						sum = 13'(pixel_data) + 13'(manual_offset);
					end
					next_s.out.valid = 1'b1;
					next_s.out.dark = 1'b0;
					next_s.out.blank = 1'b0;
					if (sum < 13'sh0)
					begin
						next_s.out.data = 10'h0;
					end
					else if (sum > $signed(`RWB_PIXEL_MAX))
					begin
						next_s.out.data = 10'h3ff;
					end
					else
					begin
						next_s.out.data = sum[9:0];
					end
					next_s.column = image_col + 4'h1;
				end
				if (frame_end)
				begin
					next_s.state = RWB_IDLE;
				end
			end
			default:
			begin
				next_s.state = RWB_IDLE;
			end
		endcase

		// Frame start restarts the dark phase from any state
		if (frame_start)
		begin
			next_s.state = RWB_DARK;
			next_s.row = 8'h0;
			next_s.kernel = 8'h0;
			next_s.column = 4'h0;
			if (dark_row_update_gate)
			begin
				next_s.dark_rows = s.dark_cfg[`RWB_DARK_COUNT_MSB:0] == 8'h0
					? 8'h01 : s.dark_cfg[`RWB_DARK_COUNT_MSB:0];
				next_s.blank_rows =
					s.dark_cfg[`RWB_BLANK_COUNT_MSB:`RWB_BLANK_COUNT_LSB];
			end
			next_s.switch_pulse = s.win_act != s.active_mask;
			next_s.active_mask = s.win_act;
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			s <= '0;
			s.state <= RWB_IDLE;
			s.cal_ctrl <= `RWB_CAL_CONTROL_RESET;
			s.win_act <= `RWB_WINDOW_ACT_RESET;
			s.dark_cfg <= `RWB_DARK_ROW_CFG_RESET;
			s.active_mask <= `RWB_WINDOW_ACT_RESET;
			s.dark_rows <= 8'h01;
		end
		else
		begin
			s <= next_s;
		end
	end

	assign reg_read_data = s.read_data;
	assign pixel_ready = s.state == RWB_IMAGE;
	assign pix_out = s.out;
	assign window_active_mask = s.active_mask;
	assign window_switch = s.switch_pulse;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	sequence end_of_dark_s;
		s.state == RWB_DARK && last_dark && !frame_start;
	endsequence

	sequence new_selection_s;
		frame_start && s.win_act != s.active_mask;
	endsequence

	dark_first_a: assert property (frame_start |=>
		s.state == RWB_DARK && s.row == 8'h0 && s.kernel == 8'h0
		##1 s.out.valid && s.out.dark)
		else $error("frame did not open with a dark sample");

	image_after_dark_a: assert property (end_of_dark_s |=>
		s.state == RWB_IMAGE && pixel_ready
		##1 !(s.out.valid && s.out.dark))
		else $error("image phase did not follow last dark sample");

	dark_raw_a: assert property (s.state == RWB_DARK && !blanked_row
		|=> s.out.dark && s.out.data == $past(dark_sample))
		else $error("dark sample was altered");

	blank_stats_a: assert property (s.out.valid && s.out.blank
		|-> s.out.data == 10'h0 && s.level == $past(s.level))
		else $error("blanked row touched the statistics");

	row_count_a: assert property (s.state == RWB_DARK
		|-> s.dark_rows != 8'h0 && s.kernel < 8'(KERNELS))
		else $error("dark row count or kernel index out of range");

	gate_hold_a: assert property (frame_start && !dark_row_update_gate
		|=> $stable(s.dark_rows) && $stable(s.blank_rows))
		else $error("dark count changed with the gate closed");

	window_switch_a: assert property (new_selection_s |=>
		window_switch && window_active_mask == $past(s.win_act))
		else $error("new window selection not recognised");

	mask_steady_a: assert property (!frame_start
		|=> !window_switch && $stable(window_active_mask))
		else $error("window mask moved outside frame start");

	manual_clip_a: assert property (s.state == RWB_IMAGE && pixel_valid
		&& !auto_mode && s.cal_ctrl[`RWB_OFFSET_SIGN_BIT]
		&& {1'b0, pixel_data} < {1'b0, manual_offset}
		|=> s.out.valid && s.out.data == 10'h0)
		else $error("manual subtraction did not clip at zero");

	manual_add_a: assert property (s.state == RWB_IMAGE && pixel_valid
		&& !auto_mode && !s.cal_ctrl[`RWB_OFFSET_SIGN_BIT]
		|=> s.out.data >= $past(pixel_data))
		else $error("manual addition lowered the pixel");

	auto_clip_a: assert property (s.state == RWB_IMAGE && pixel_valid
		&& auto_mode && 11'(pixel_data) + 11'(black_level_target)
		< 11'(s.level[image_col][12:3])
		|=> s.out.data == 10'h0)
		else $error("negative compensated value not clipped");
endmodule

// *** rwb_regs.svh ***
`ifndef RWB_REGS_SVH
`define RWB_REGS_SVH

// Register offsets on the serial register port
`define RWB_CAL_CONTROL_OFFSET   9'h081
`define RWB_WINDOW_ACT_OFFSET    9'h0c3
`define RWB_DARK_ROW_CFG_OFFSET  9'h0c5
`define RWB_GEOMETRY_BASE        9'h100
`define RWB_GEOMETRY_LAST        9'h12f
`define RWB_GEOMETRY_WORDS       48

// Field positions
`define RWB_AUTO_ENABLE_BIT      0
`define RWB_MANUAL_OFFSET_LSB    1
`define RWB_MANUAL_OFFSET_MSB    9
`define RWB_OFFSET_SIGN_BIT      10
`define RWB_DARK_COUNT_MSB       7
`define RWB_BLANK_COUNT_LSB      8
`define RWB_BLANK_COUNT_MSB      12

// Reset values
`define RWB_CAL_CONTROL_RESET    16'h0001
`define RWB_WINDOW_ACT_RESET     16'h0001
`define RWB_DARK_ROW_CFG_RESET   16'h0001

// Readout geometry
`define RWB_KERNELS              162
`define RWB_COLUMNS              16
`define RWB_PIXEL_MAX            13'h03ff

`endif
